//--- common/adc_port_map.svh
`ifndef ADC_PORT_MAP_SVH
`define ADC_PORT_MAP_SVH

// Result word width and sign position
`define RESULT_W          12
`define RESULT_MSB        11

// Clock period in ns
`define CLK_PERIOD_NS     50

// Timing figures in ns
`define CONV_PULSE_NS     40
`define DATA_VALID_MAX_NS 1095
`define BUSY_AFTER_MIN_NS 20
`define BUSY_AFTER_MAX_NS 120
`define ACQ_MAX_NS        230
`define CONV_SPACING_NS   1250

// Cycle counts derived from the figures
`define DATA_VALID_CYC    ((`DATA_VALID_MAX_NS) / (`CLK_PERIOD_NS))
`define BUSY_AFTER_CYC    (((`BUSY_AFTER_MIN_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define ACQ_CYC           ((`ACQ_MAX_NS) / (`CLK_PERIOD_NS))
// Edges from a pin change to start detection
`define SYNC_LAT_CYC      3

// Result FIFO shape
`define FIFO_DEPTH        4
`define FIFO_AW           2

// Reset values
`define RESULT_RST        12'h000
`define LFSR_SEED         12'hA5C

`endif

//--- common/adc_port_pkg.sv
package adc_port_pkg;

  `include "adc_port_map.svh"

  typedef logic [`RESULT_W-1:0] result_t;

  // Bus pin bundle: output value and per-bit enables
  typedef struct packed {
    result_t result_bits;
    result_t result_oe;
  } result_bus_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CONV = 4'b0010,
    ST_LOAD = 4'b0100,
    ST_HOLD = 4'b1000
  } conv_state_t;

endpackage

//--- hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import adc_port_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  // Clock and control
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  // Asynchronous pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_rst_val,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // Two-flop synchroniser per bit
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
        begin
          stage1[g] <= i_rst_val[g];
          o_sync[g] <= i_rst_val[g];
        end
        else if (i_ce)
        begin
          stage1[g] <= i_async[g];
          o_sync[g] <= stage1[g];
        end
      end
    end
  endgenerate

endmodule

//--- hw/result_fifo.sv
`timescale 1ns/1ps
module result_fifo
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4,
  parameter int AW    = 2
)
(
  // Clock and control
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  // Fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign o_ready = (count != DEPTH[AW:0]);
  assign o_valid = (count != '0);
  assign push    = i_ce && i_valid && o_ready;
  assign pop     = i_ce && o_valid && i_ready;
  assign o_data  = mem[rd_ptr];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_data;
    end
  end

  // ----------------------------------------------------------------
  // Pointers and fill count
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

//--- hw/sar_adc_convert_read_port.sv
`timescale 1ns/1ps
module sar_adc_convert_read_port
  import adc_port_pkg::*;
(
  // Clock, reset, enable
  input  wire logic           i_clk,
  input  wire logic           i_rst,
  input  wire logic           i_ce,
  // Controller pins
  input  wire logic           i_select_n,
  input  wire logic           i_read_conv,
  output logic                o_busy_n,
  // Result bus pins
  output logic [`RESULT_W-1:0] o_result_bits,
  output logic [`RESULT_W-1:0] o_result_oe,
  // Analog core side
  output logic                o_hold,
  input  wire logic           i_sample_valid,
  input  wire logic [`RESULT_W-1:0] i_sample,
  output logic                o_sample_ready
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [5:0] DATA_CYC  = 6'(`DATA_VALID_CYC);
  localparam logic [5:0] BUSY_CYC  = 6'(`BUSY_AFTER_CYC);
  localparam logic [5:0] ACQ_CYC   = 6'(`ACQ_CYC);
  // Pin to start detection latency: two sync flops and the state register
  localparam logic [5:0] SYNC_CYC  = 6'(`SYNC_LAT_CYC);
  // Last counter value of the conversion phase, leaving the load and busy gap
  localparam logic [5:0] CONV_LAST = DATA_CYC - BUSY_CYC - 6'h02 - SYNC_CYC;
  // Counter value at which busy is released, counted from entry to ST_CONV
  localparam logic [5:0] DONE_CYC  = DATA_CYC - SYNC_CYC - 6'h01;

  logic [1:0]   pins_sync;
  logic         select_n;
  logic         read_conv;
  logic         select_n_d;
  logic         read_conv_d;
  logic         start_lvl;
  logic         start_lvl_d;
  logic         start_req;
  logic         read_en;
  conv_state_t  state;
  conv_state_t  next_state;
  logic [5:0]   cyc;
  logic [5:0]   acq_cnt;
  result_t      result_reg;
  result_t      fifo_data;
  logic         fifo_valid;
  logic         fifo_ready;
  logic         fifo_pop;
  result_bus_t  bus;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Both pins idle high, so reset fills the stages with ones
  pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_async   ({i_select_n, i_read_conv}),
    .i_rst_val (2'h3),
    .o_sync    (pins_sync)
  );

  assign select_n  = pins_sync[1];
  assign read_conv = pins_sync[0];

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      select_n_d  <= 1'b1;
      read_conv_d <= 1'b1;
    end
    else if (i_ce)
    begin
      select_n_d  <= select_n;
      read_conv_d <= read_conv;
    end
  end

  // Start level one cycle back, rebuilt from the delayed pins
  assign start_lvl_d = !select_n_d && !read_conv_d;

  // Both low together forms the start level; its rising edge is the later fall
  assign start_lvl = !select_n && !read_conv;
  // Covers falling read/convert with select low and falling select with read/convert low
  assign start_req = start_lvl && !start_lvl_d;

  // ----------------------------------------------------------------
  // Conversion state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (start_req)
        begin
          next_state = ST_CONV;
        end
      end
      ST_CONV:
      begin
        // Starts here are ignored while busy is low
        if (cyc == CONV_LAST && fifo_valid)
        begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        next_state = ST_HOLD;
      end
      ST_HOLD:
      begin
        if (cyc == DONE_CYC)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= ST_IDLE;
    end
    else if (i_ce)
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Conversion cycle counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cyc <= '0;
    end
    else if (i_ce)
    begin
      if (state == ST_IDLE)
      begin
        cyc <= '0;
      end
      else if (!(state == ST_CONV && cyc == CONV_LAST))
      begin
        cyc <= cyc + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------
  // Loading waits at the last count until the stream holds a word
  assign fifo_pop = (state == ST_CONV) && (cyc == CONV_LAST);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      result_reg <= `RESULT_RST;
    end
    else if (i_ce && fifo_pop && fifo_valid)
    begin
      result_reg <= fifo_data;
    end
  end

  // ----------------------------------------------------------------
  // Sample stream buffer
  // ----------------------------------------------------------------
  result_fifo #(
    .WIDTH (`RESULT_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_valid (i_sample_valid),
    .o_ready (fifo_ready),
    .i_data  (i_sample),
    .o_valid (fifo_valid),
    .i_ready (fifo_pop),
    .o_data  (fifo_data)
  );

  assign o_sample_ready = fifo_ready;

  // ----------------------------------------------------------------
  // Sample/hold and acquisition
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_hold  <= 1'b0;
      acq_cnt <= '0;
    end
    else if (i_ce)
    begin
      if (start_req && state == ST_IDLE)
      begin
        o_hold <= 1'b1;
      end
      else if (state == ST_LOAD)
      begin
        o_hold  <= 1'b0;
        acq_cnt <= ACQ_CYC;
      end
      else if (acq_cnt != '0)
      begin
        acq_cnt <= acq_cnt - 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Busy output
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_busy_n <= 1'b1;
    end
    else if (i_ce)
    begin
      if (start_req && state == ST_IDLE)
      begin
        o_busy_n <= 1'b0;
      end
      // Released only once the loaded result stands on the pins
      else if (state == ST_HOLD && next_state == ST_IDLE)
      begin
        o_busy_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Three-state result bus
  // ----------------------------------------------------------------
  // Enable follows levels, so falling select or rising read/convert both open it
  assign read_en = !select_n && read_conv && (state == ST_IDLE) && o_busy_n;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      bus <= '0;
    end
    else if (i_ce)
    begin
      bus.result_bits <= result_reg;
      bus.result_oe   <= {`RESULT_W{read_en}};
    end
  end

  assign o_result_bits = bus.result_bits;
  assign o_result_oe   = bus.result_oe;

endmodule

//--- testbench/adc_port_props.sv
`timescale 1ns/1ps
`include "adc_port_map.svh"
module adc_port_props
  import adc_port_pkg::*;
(
  // Clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_rst,
  // Controller pins and sample/hold output
  input wire logic                 i_select_n,
  input wire logic                 i_read_conv,
  input wire logic                 o_busy_n,
  input wire logic                 o_hold,
  // Result bus
  input wire logic [`RESULT_W-1:0] o_result_bits,
  input wire logic [`RESULT_W-1:0] o_result_oe
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_start_by_rc: assert property ($fell(i_read_conv) && !i_select_n && o_busy_n |-> ##[1:4] !o_busy_n)
    else $error("no busy after convert edge");
  a_start_by_cs: assert property ($fell(i_select_n) && !i_read_conv && o_busy_n |-> ##[1:4] !o_busy_n)
    else $error("no busy after select edge");
  a_hold_at_start: assert property ($fell(o_busy_n) |-> o_hold)
    else $error("busy fell without hold");
  a_busy_span: assert property ($fell(o_busy_n) |-> (!o_busy_n)[*8] ##[1:16] o_busy_n)
    else $error("busy low span wrong");
  a_rc_low_hiz: assert property ((!i_read_conv)[*5] |-> o_result_oe == '0)
    else $error("bus driven with convert low");
  a_sel_high_hiz: assert property (i_select_n[*5] |-> o_result_oe == '0)
    else $error("bus driven while deselected");
  a_conv_hiz: assert property (!o_busy_n |-> o_result_oe == '0)
    else $error("bus driven while busy");
  a_oe_on_read: assert property ((!i_select_n && i_read_conv && o_busy_n)[*6] |-> &o_result_oe)
    else $error("bus not driven in read mode");
  a_bits_steady: assert property (o_busy_n && $past(o_busy_n) |-> $stable(o_result_bits))
    else $error("result changed while idle");
  a_track_after: assert property ($rose(o_busy_n) |-> !o_hold)
    else $error("still holding after conversion");

  c_done: cover property ($rose(o_busy_n));
  c_read: cover property (&o_result_oe);
  c_cs_start: cover property ($fell(i_select_n) && !i_read_conv);
endmodule

bind sar_adc_convert_read_port adc_port_props adc_port_props_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_select_n(i_select_n), .i_read_conv(i_read_conv),
  .o_busy_n(o_busy_n), .o_hold(o_hold), .o_result_bits(o_result_bits), .o_result_oe(o_result_oe)
);

//--- testbench/sample_source.sv
`timescale 1ns/1ps
module sample_source
#(
  parameter int           W     = 12,
  parameter int           N     = 8,
  parameter logic [N*W-1:0] TABLE = '0,
  parameter int           GAP   = 3
)
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Sample stream
  input  wire logic         i_ready,
  output logic              o_valid,
  output logic      [W-1:0] o_data
);
  int idx;
  int gap_n;

  // ----
  // Word source with stalls
  // ----
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_valid <= 1'b0;
      o_data  <= '0;
      idx     <= 0;
      gap_n   <= 0;
    end
    else if (o_valid && i_ready)
    begin
      idx     <= idx + 1;
      o_valid <= 1'b0;
      o_data  <= ~o_data;
      gap_n   <= GAP;
    end
    else if (!o_valid)
    begin
      o_data <= ~o_data;
      if (gap_n > 0)
        gap_n <= gap_n - 1;
      else if (idx < N)
      begin
        o_valid <= 1'b1;
        o_data  <= TABLE[idx*W +: W];
      end
    end
  end
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import adc_port_pkg::*;
  localparam int N = 8;
  localparam logic [N*12-1:0] TABLE = {12'h5A3, 12'h0F0, 12'hA5A, 12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'h123};

  logic    i_clk      = 1'b0;
  logic    i_rst      = 1'b1;
  logic    i_select_n = 1'b1;
  logic    i_read_conv = 1'b1;
  logic    busy_n;
  logic    hold;
  logic    sv;
  logic    ready;
  result_t sd;
  result_t bits;
  result_t oe;
  int      n_fail = 0;
  int      samples_checked = 0;
  int      k = 0;

  initial forever #25 i_clk = ~i_clk;

  sar_adc_convert_read_port sar_adc_convert_read_port_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_select_n(i_select_n), .i_read_conv(i_read_conv),
    .o_busy_n(busy_n), .o_result_bits(bits), .o_result_oe(oe), .o_hold(hold),
    .i_sample_valid(sv), .i_sample(sd), .o_sample_ready(ready)
  );

  sample_source #(.W(12), .N(N), .TABLE(TABLE), .GAP(3)) sample_source_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_ready(ready), .o_valid(sv), .o_data(sd)
  );

  // ----
  // Helpers
  // ----
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task check12(input string nm, input result_t e, input result_t g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task check1(input string nm, input logic e, input logic g);
    check12(nm, {11'h000, e}, {11'h000, g});
  endtask

  task check_rng(input string nm, input int lo, input int hi, input int g);
    samples_checked++;
    if (g < lo || g > hi)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task pins(input logic s, input logic r);
    @(posedge i_clk);
    i_select_n  <= s;
    i_read_conv <= r;
  endtask

  task settle(input int c);
    repeat (c) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // ----
  // Scenarios
  // ----
  task t_reset;
    check1("busy_n", 1'b1, busy_n);
    check1("hold", 1'b0, hold);
    check12("oe", 12'h000, oe);
  endtask

  task t_conv(input bit by_cs, input bit poke);
    int n;
    int t;
    result_t e;
    e = TABLE[k*12 +: 12];
    k++;
    t = 0;
    if (by_cs)
      pins(1'b1, 1'b0);
    else
      pins(1'b0, 1'b1);
    settle(4);
    pins(1'b0, 1'b0);
    for (n = 1; n < 40; n++)
    begin
      @(posedge i_clk);
      if (poke && n == 6)
        i_read_conv <= 1'b1;
      if (poke && n == 10)
        i_read_conv <= 1'b0;
      @(negedge i_clk);
      if (n == 5)
      begin
        check1("busy_n start", 1'b0, busy_n);
        check1("hold start", 1'b1, hold);
      end
      if (n == 10)
        check12("oe conv", 12'h000, oe);
      if (bits === e && t == 0)
        t = n;
      if (busy_n === 1'b1 && n > 5)
        break;
    end
    check_rng("data delay", 1, 21, t);
    check_rng("busy after data", 1, 2, n - t);
    check12("bits at busy", e, bits);
    check1("hold end", 1'b0, hold);
    if (by_cs)
      pins(1'b1, 1'b1);
    pins(1'b0, 1'b1);
    settle(5);
    check12("oe read", 12'hFFF, oe);
    check12("bits read", e, bits);
    pins(1'b1, 1'b1);
    settle(5);
    check12("oe off", 12'h000, oe);
  endtask

  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    settle(2);
    t_reset;
    t_conv(0, 0);
    t_conv(1, 0);
    t_conv(0, 1);
    t_conv(1, 1);
    t_conv(0, 0);
    t_conv(1, 0);
    finish_test;
  end

  initial
  begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    finish_test;
  end
endmodule
